/* logic/ttl_io_pkg.sv */
// Package of constants and types for the pump logic-level I/O controller
package ttl_io_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  // Debounce settle time in microseconds and the cycle count derived from the 100 MHz clock
  localparam int CLK_MHZ = 100;
  localparam int DEBOUNCE_US = 1;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
  localparam int DEBOUNCE_W = 8;

  // ----------------------------------------
  // Trigger mode setting codes
  // ----------------------------------------
  localparam logic [3:0] TRIG_OFF = 4'h0;
  localparam logic [3:0] TRIG_FOOT = 4'h1;
  localparam logic [3:0] TRIG_FOOT_HOLD = 4'h2;
  localparam logic [3:0] TRIG_FOOT_REV = 4'h3;
  localparam logic [3:0] TRIG_LEVEL_CTRL = 4'h4;
  localparam logic [3:0] TRIG_START_ONLY = 4'h5;
  localparam logic [3:0] TRIG_START_REV = 4'h6;
  localparam logic [3:0] TRIG_STOP_ONLY = 4'h7;
  localparam logic [3:0] TRIG_STOP_REV = 4'h8;
  localparam logic [3:0] TRIG_RUN_LOW = 4'h9;
  localparam logic [3:0] TRIG_RUN_HIGH = 4'hA;
  localparam logic [3:0] TRIG_STOP_LOW = 4'hB;
  localparam logic [3:0] TRIG_STOP_HIGH = 4'hC;

  // ----------------------------------------
  // Motor-running output setting codes
  // ----------------------------------------
  localparam logic [1:0] RUN_OUT_PUMPING = 2'h0;
  localparam logic [1:0] RUN_OUT_PUMP_PAUSE = 2'h1;

  // ----------------------------------------
  // Direction input mode codes
  // ----------------------------------------
  localparam logic DIR_MODE_RECIP = 1'h0;
  localparam logic DIR_MODE_DUAL = 1'h1;

  // ----------------------------------------
  // Program I/O functions being executed
  // ----------------------------------------
  localparam logic [2:0] FN_NONE = 3'h0;
  localparam logic [2:0] FN_EDGE_EVENT = 3'h1;
  localparam logic [2:0] FN_EITHER_EVENT = 3'h2;
  localparam logic [2:0] FN_COND_INPUT = 3'h3;
  localparam logic [2:0] FN_WAIT_TRIGGER = 3'h4;
  localparam logic [2:0] FN_SET_OUTPUT = 3'h5;

  // Phase numbers and reset values
  localparam int PHASE_W = 6;
  localparam logic DIR_RESET = 1'h1;
  localparam logic PROG_OUT_RESET = 1'h0;

  // Program run state
  typedef enum logic [1:0] {st_stopped, st_running, st_wait_trig} run_state_t;

endpackage : ttl_io_pkg

/* logic/input_conditioner.sv */
// Synchroniser, debouncer and edge detector for one external input
`timescale 1ns/1ns
`default_nettype none
module input_conditioner
  import ttl_io_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Raw pin
  input wire logic pin,
  // Conditioned outputs
  output logic level,
  output logic rise,
  output logic fall
);

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  logic sync1; // Only read by sync2
  logic sync2;
  logic [DEBOUNCE_W-1:0] count; // Stable-time counter
  wire logic differs = (sync2 != level);
  wire logic settled = differs && (count == DEBOUNCE_W'(DEBOUNCE_CYCLES - 1));

  // Pin idles high through a pull-up, so reset to high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 1'h1;
      sync2 <= 1'h1;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
    end
  end

  // ----------------------------------------
  // Debounce: accept a new level only after it stayed put
  // ----------------------------------------
  // Bounces restart the count, so one physical change gives one edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      level <= 1'h1;
      rise <= 1'h0;
      fall <= 1'h0;
    end else begin
      count <= (differs && !settled) ? count + 1'b1 : '0;
      rise <= settled && sync2;
      fall <= settled && !sync2;
      if (settled) begin
        level <= sync2;
      end
    end
  end

  // One detected edge per accepted level change
  edge_once_a: assert property (@(posedge clk) disable iff (!nrst)
    (rise || fall) |=> !(rise || fall)) else $error("edge pulse longer than one cycle");
  edge_level_a: assert property (@(posedge clk) disable iff (!nrst)
    rise |-> level) else $error("rise without high level");

endmodule : input_conditioner
`default_nettype wire

/* logic/direction_control.sv */
// Pumping direction state driven by keypad and the direction input
`timescale 1ns/1ns
`default_nettype none
module direction_control
  import ttl_io_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration and qualifiers
  input wire logic dir_mode,
  input wire logic dir_key_allowed,
  input wire logic ext_ignore,
  // Events
  input wire logic dir_key_press,
  input wire logic dir_rise,
  input wire logic dir_fall,
  // State
  output logic infuse
);

  // ----------------------------------------
  // Edge decode per mode
  // ----------------------------------------
  // Reciprocating: fall while withdrawing, rise while infusing
  // Dual: rise while withdrawing, fall while infusing
  wire logic to_infuse_edge = (dir_mode == DIR_MODE_RECIP) ? dir_fall : dir_rise;
  wire logic to_withdraw_edge = (dir_mode == DIR_MODE_RECIP) ? dir_rise : dir_fall;
  wire logic ext_ok = dir_key_allowed && !ext_ignore;
  wire logic ext_flip = ext_ok && (infuse ? to_withdraw_edge : to_infuse_edge);
  wire logic key_flip = dir_key_press && dir_key_allowed;

  // ----------------------------------------
  // Direction register
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      infuse <= DIR_RESET;
    end else if (key_flip || ext_flip) begin
      infuse <= !infuse;
    end
  end

  dir_blocked_a: assert property (@(posedge clk) disable iff (!nrst)
    (ext_ignore && !dir_key_press) |=> $stable(infuse)) else $error("direction moved while ignored");
  dir_recip_a: assert property (@(posedge clk) disable iff (!nrst)
    (dir_mode == DIR_MODE_RECIP && !infuse && dir_rise && !dir_key_press) |=> !infuse)
    else $error("rise changed withdraw in reciprocating mode");

endmodule : direction_control
`default_nettype wire

/* logic/pump_ttl_io_control.sv */
// Logic-level I/O controller of the programmable pump
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Ignore trigger and direction while editing or alarmed
// - Foot switch: falling edge toggles run state
// - Hold mode: fall starts, rise stops
// - Reversed foot switch: rising edge toggles
// - Level control: fall stops, rise starts
// - Start-only modes start on one edge only
// - Stop-only modes stop on one edge only
// - Four level modes: run/stop on low/high
// - Trigger off ignores the input entirely
// - Options route stop trigger or key to trap
// - Motor output follows pumping or pumping/pause setting
// - Direction input acts like direction key
// - Reciprocating mode: fall withdraw-to-infuse, rise reverse
// - Dual mode: rise withdraw-to-infuse, fall reverse
// - Direction output high infuse, low withdraw
// - Set-output function drives program output level
// - Edge event: falling edge jumps to phase
// - Either-edge event: any edge jumps to phase
// - Conditional input: low level jumps to phase
// - Zero pause waits for trigger activation, resumes
// - Host reads input levels and sets output
module pump_ttl_io_control
  import ttl_io_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // External pins
  input wire logic trigger_pin,
  input wire logic direction_pin,
  input wire logic event_pin,
  input wire logic prog_in_pin,
  output logic motor_run_pin,
  output logic direction_out_pin,
  output logic prog_out_pin,
  // Configuration
  input wire logic [3:0] trigger_mode_setting,
  input wire logic stop_trigger_to_trap,
  input wire logic stop_key_to_trap,
  input wire logic [1:0] run_out_setting,
  input wire logic dir_mode,
  // Keypad and alarm state
  input wire logic keypad_editing,
  input wire logic alarm_active,
  input wire logic start_stop_key,
  input wire logic dir_key,
  input wire logic dir_key_allowed,
  // Program sequencer
  input wire logic start_allowed,
  input wire logic program_done,
  input wire logic pause_timer_active,
  input wire logic [2:0] prog_function,
  input wire logic prog_function_strobe,
  input wire logic [PHASE_W-1:0] prog_phase_arg,
  input wire logic prog_level_arg,
  output logic pumping,
  output logic waiting_trigger,
  output logic jump_req,
  output logic [PHASE_W-1:0] jump_phase,
  output logic event_trap,
  // Serial host access
  input wire logic host_out_write,
  input wire logic host_out_level,
  output logic [3:0] host_in_levels
);

  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  logic trig_lvl, trig_rise, trig_fall;
  logic dir_lvl, dir_rise, dir_fall;
  logic ev_lvl, ev_rise, ev_fall;
  logic pin_lvl;
  logic infuse; // Current direction
  run_state_t state; // Program run state
  run_state_t next_state;
  logic [2:0] armed_fn; // Function waiting on an input
  logic [PHASE_W-1:0] armed_phase; // Its target phase

  input_conditioner u_trig (
    .clk(clk),
    .nrst(nrst),
    .pin(trigger_pin),
    .level(trig_lvl),
    .rise(trig_rise),
    .fall(trig_fall)
  );
  input_conditioner u_dir (
    .clk(clk),
    .nrst(nrst),
    .pin(direction_pin),
    .level(dir_lvl),
    .rise(dir_rise),
    .fall(dir_fall)
  );
  input_conditioner u_ev (
    .clk(clk),
    .nrst(nrst),
    .pin(event_pin),
    .level(ev_lvl),
    .rise(ev_rise),
    .fall(ev_fall)
  );
  input_conditioner u_pin (
    .clk(clk),
    .nrst(nrst),
    .pin(prog_in_pin),
    .level(pin_lvl),
    .rise(),
    .fall()
  );

  // ----------------------------------------
  // Trigger decode
  // ----------------------------------------
  // Keypad edits and alarms shut out the external controls
  wire logic ext_ignore = keypad_editing || alarm_active;
  wire logic trig_on = !ext_ignore && (trigger_mode_setting != TRIG_OFF);

  // Edge-mode actions as toggle, start and stop requests
  wire logic edge_toggle = trig_on && (
    (trigger_mode_setting == TRIG_FOOT && trig_fall) ||
    (trigger_mode_setting == TRIG_FOOT_REV && trig_rise));
  wire logic edge_start = trig_on && (
    (trigger_mode_setting == TRIG_FOOT_HOLD && trig_fall) ||
    (trigger_mode_setting == TRIG_LEVEL_CTRL && trig_rise) ||
    (trigger_mode_setting == TRIG_START_ONLY && trig_fall) ||
    (trigger_mode_setting == TRIG_START_REV && trig_rise));
  wire logic edge_stop = trig_on && (
    (trigger_mode_setting == TRIG_FOOT_HOLD && trig_rise) ||
    (trigger_mode_setting == TRIG_LEVEL_CTRL && trig_fall) ||
    (trigger_mode_setting == TRIG_STOP_ONLY && trig_fall) ||
    (trigger_mode_setting == TRIG_STOP_REV && trig_rise));

  // Level modes hold the state while the level stands
  wire logic level_run = trig_on && (
    (trigger_mode_setting == TRIG_RUN_LOW && !trig_lvl) ||
    (trigger_mode_setting == TRIG_RUN_HIGH && trig_lvl));
  wire logic level_stop = trig_on && (
    (trigger_mode_setting == TRIG_STOP_LOW && !trig_lvl) ||
    (trigger_mode_setting == TRIG_STOP_HIGH && trig_lvl));

  // Any activation of the trigger, used to leave a zero pause
  wire logic trig_activation = edge_toggle || edge_start || level_run;

  // A stop request may be diverted to the event trap
  wire logic trig_stop_req = edge_stop || level_stop || (edge_toggle && state == st_running);
  wire logic trig_stop = trig_stop_req && !stop_trigger_to_trap;
  wire logic trap_trig = trig_stop_req && stop_trigger_to_trap && state == st_running;
  wire logic key_stop_req = start_stop_key && state == st_running;
  wire logic key_stop = key_stop_req && !stop_key_to_trap;
  wire logic trap_key = key_stop_req && stop_key_to_trap;

  // Start-only starts only when the program permits it
  wire logic start_req = (edge_start || level_run || (edge_toggle && state == st_stopped) ||
    (start_stop_key && state == st_stopped)) && start_allowed;

  // ----------------------------------------
  // Run state
  // ----------------------------------------
  // Stop wins over start so a stop level is not overridden, unless stop_trigger_to_trap diverts it and a start then wins
  always_comb begin
    next_state = state;
    case (state)
      st_stopped: begin
        if (start_req && !(trig_stop || key_stop)) begin
          next_state = st_running;
        end
      end
      st_running: begin
        if (trig_stop || key_stop || program_done) begin
          next_state = st_stopped;
        end else if (prog_function_strobe && prog_function == FN_WAIT_TRIGGER) begin
          next_state = st_wait_trig;
        end
      end
      st_wait_trig: begin
        if (key_stop || trig_stop) begin
          next_state = st_stopped;
        end else if (trig_activation) begin
          next_state = st_running;
        end
      end
      default: begin
        next_state = st_stopped;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= st_stopped;
    end else begin
      state <= next_state;
    end
  end

  assign pumping = (state == st_running);
  assign waiting_trigger = (state == st_wait_trig);

  // ----------------------------------------
  // Program input functions
  // ----------------------------------------
  // The armed function watches its input until it fires, the run state is stopped, or another event function replaces it
  wire logic arm_now = prog_function_strobe && (prog_function == FN_EDGE_EVENT ||
    prog_function == FN_EITHER_EVENT);
  wire logic ev_hit = (armed_fn == FN_EDGE_EVENT && ev_fall) ||
    (armed_fn == FN_EITHER_EVENT && (ev_rise || ev_fall));
  wire logic cond_hit = prog_function_strobe && prog_function == FN_COND_INPUT && !pin_lvl;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed_fn <= FN_NONE;
      armed_phase <= '0;
    end else if (arm_now) begin
      armed_fn <= prog_function;
      armed_phase <= prog_phase_arg;
    end else if (ev_hit || state == st_stopped) begin
      armed_fn <= FN_NONE;
    end
  end

  // Jump request and its phase, one-cycle pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      jump_req <= 1'h0;
      jump_phase <= '0;
      event_trap <= 1'h0;
    end else begin
      jump_req <= ev_hit || cond_hit;
      jump_phase <= cond_hit ? prog_phase_arg : armed_phase;
      event_trap <= trap_trig || trap_key;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Program output: set by program or by host, last writer wins, program wins when both write in one cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_out_pin <= PROG_OUT_RESET;
    end else if (prog_function_strobe && prog_function == FN_SET_OUTPUT) begin
      prog_out_pin <= prog_level_arg;
    end else if (host_out_write) begin
      prog_out_pin <= host_out_level;
    end
  end

  wire logic next_motor = (run_out_setting == RUN_OUT_PUMPING) ? pumping :
    (run_out_setting == RUN_OUT_PUMP_PAUSE) ? (pumping || pause_timer_active) : 1'h0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      motor_run_pin <= 1'h0;
      direction_out_pin <= DIR_RESET;
      host_in_levels <= 4'hF;
    end else begin
      motor_run_pin <= next_motor;
      direction_out_pin <= infuse;
      host_in_levels <= {pin_lvl, ev_lvl, dir_lvl, trig_lvl};
    end
  end

  direction_control u_dirc (
    .clk(clk),
    .nrst(nrst),
    .dir_mode(dir_mode),
    .dir_key_allowed(dir_key_allowed),
    .ext_ignore(ext_ignore),
    .dir_key_press(dir_key),
    .dir_rise(dir_rise),
    .dir_fall(dir_fall),
    .infuse(infuse)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence foot_fall_s;
    trigger_mode_setting == TRIG_FOOT && !ext_ignore && trig_fall && state == st_stopped &&
      start_allowed && !start_stop_key;
  endsequence

  ignore_trig_a: assert property (@(posedge clk) disable iff (!nrst)
    (ext_ignore && !start_stop_key && !program_done && !prog_function_strobe) |=> $stable(state))
    else $error("run state moved while ignored");
  foot_start_a: assert property (@(posedge clk) disable iff (!nrst)
    foot_fall_s |=> state == st_running) else $error("foot switch fall did not start");
  trig_off_a: assert property (@(posedge clk) disable iff (!nrst)
    (trigger_mode_setting == TRIG_OFF && !start_stop_key && !program_done && !prog_function_strobe)
    |=> $stable(state)) else $error("trigger off changed state");
  motor_out_a: assert property (@(posedge clk) disable iff (!nrst)
    (run_out_setting > RUN_OUT_PUMP_PAUSE) |=> !motor_run_pin) else $error("motor output high");
  dir_out_a: assert property (@(posedge clk) disable iff (!nrst)
    1'h1 |=> direction_out_pin == $past(infuse)) else $error("direction output wrong");
  set_out_a: assert property (@(posedge clk) disable iff (!nrst)
    (prog_function_strobe && prog_function == FN_SET_OUTPUT) |=> prog_out_pin == $past(prog_level_arg))
    else $error("program output not set");
  cond_jump_a: assert property (@(posedge clk) disable iff (!nrst)
    cond_hit |=> jump_req && jump_phase == $past(prog_phase_arg)) else $error("conditional jump lost");
  stop_only_a: assert property (@(posedge clk) disable iff (!nrst)
    (trigger_mode_setting == TRIG_STOP_ONLY && state == st_stopped && !start_stop_key) |=> state != st_running)
    else $error("stop-only mode started");

endmodule : pump_ttl_io_control
`default_nettype wire

/* test/trigger_source_model.sv */
// Behavioural model of the foot switch or automation controller at the pins
`timescale 1ns/1ns
`default_nettype none
module trigger_source_model (
  // Clock
  input wire logic clk,
  // Pins into the pump, pulled up when idle
  output logic trigger_pin,
  output logic direction_pin,
  output logic event_pin,
  output logic prog_in_pin
);
  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  // Index order: 0 trigger, 1 direction, 2 event, 3 program input
  logic [3:0] lvl = 4'hF;
  assign {prog_in_pin, event_pin, direction_pin, trigger_pin} = lvl;

  // Change one pin just after an edge, then hold it well past the debounce
  // window, since a shorter pulse would be filtered as contact bounce
  task automatic set_pin(input int idx, input int val);
    @(posedge clk);
    lvl[idx] <= 1'(val);
    repeat (120) @(posedge clk);
  endtask : set_pin
endmodule : trigger_source_model
`default_nettype wire

/* test/pump_ttl_io_control_test.sv */
// Self-checking testbench of the pump logic-level I/O controller
`timescale 1ns/1ns
`default_nettype none
module pump_ttl_io_control_test
  import ttl_io_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  wire logic trig_p, dir_p, evt_p, pin_p;
  // Configuration and keypad, all driven by the bench
  logic [3:0] mode = TRIG_OFF;
  logic [1:0] run_set = RUN_OUT_PUMPING;
  logic trap_trig = 1'b0, trap_key = 1'b0, dir_mode = DIR_MODE_RECIP;
  logic keypad_editing = 1'b0, alarm_active = 1'b0, start_stop_key = 1'b0;
  logic dir_key = 1'b0, dir_key_allowed = 1'b1, start_allowed = 1'b1;
  logic program_done = 1'b0, pause_timer_active = 1'b0;
  logic [2:0] prog_function = FN_NONE;
  logic prog_function_strobe = 1'b0, prog_level_arg = 1'b0;
  logic [PHASE_W-1:0] prog_phase_arg = '0;
  logic host_out_write = 1'b0, host_out_level = 1'b0;
  // Outputs of the block
  logic motor, dir_out, prog_out, pumping, waiting, jump_req, event_trap;
  logic [PHASE_W-1:0] jump_phase, jump_got;
  logic [3:0] host_in;
  // Pulse catchers and bookkeeping
  logic jump_seen = 1'b0, trap_seen = 1'b0;
  int n_mismatch = 0, tests_run = 0, cycles = 0;

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  trigger_source_model trigger_source_model_inst (.clk(clk), .trigger_pin(trig_p),
    .direction_pin(dir_p), .event_pin(evt_p), .prog_in_pin(pin_p));
  pump_ttl_io_control pump_ttl_io_control_inst (.clk(clk), .nrst(nrst), .trigger_pin(trig_p),
    .direction_pin(dir_p), .event_pin(evt_p), .prog_in_pin(pin_p), .motor_run_pin(motor),
    .direction_out_pin(dir_out), .prog_out_pin(prog_out), .trigger_mode_setting(mode),
    .stop_trigger_to_trap(trap_trig), .stop_key_to_trap(trap_key), .run_out_setting(run_set),
    .dir_mode(dir_mode), .keypad_editing(keypad_editing), .alarm_active(alarm_active),
    .start_stop_key(start_stop_key), .dir_key(dir_key), .dir_key_allowed(dir_key_allowed),
    .start_allowed(start_allowed), .program_done(program_done),
    .pause_timer_active(pause_timer_active), .prog_function(prog_function),
    .prog_function_strobe(prog_function_strobe), .prog_phase_arg(prog_phase_arg),
    .prog_level_arg(prog_level_arg), .pumping(pumping), .waiting_trigger(waiting),
    .jump_req(jump_req), .jump_phase(jump_phase), .event_trap(event_trap),
    .host_out_write(host_out_write), .host_out_level(host_out_level), .host_in_levels(host_in));

  // ----------------------------------------
  // Clock, pulse catchers, timeout
  // ----------------------------------------
  always #5 clk = ~clk;
  // One-cycle pulses are latched so a later check cannot miss them
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (jump_req === 1'b1) begin
      jump_seen <= 1'b1;
      jump_got <= jump_phase;
    end
    if (event_trap === 1'b1) trap_seen <= 1'b1;
    if (cycles == 30000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk
  task automatic run(input int e);
    chk("pumping", 8'(e), 8'(pumping));
  endtask : run
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic pin(input int i, input int v);
    trigger_source_model_inst.set_pin(i, v);
  endtask : pin
  task automatic set_mode(input logic [3:0] m);
    @(posedge clk) mode <= m;
    tick(3);
  endtask : set_mode
  // Keypad start/stop press, one cycle long
  task automatic key();
    @(posedge clk) start_stop_key <= 1'b1;
    @(posedge clk) start_stop_key <= 1'b0;
    tick(3);
  endtask : key
  task automatic done();
    @(posedge clk) program_done <= 1'b1;
    @(posedge clk) program_done <= 1'b0;
    tick(3);
  endtask : done
  // Program function with its arguments, qualified by a one-cycle strobe
  task automatic fn(input logic [2:0] f, input logic [PHASE_W-1:0] ph, input logic lv);
    @(posedge clk);
    prog_function <= f;
    prog_phase_arg <= ph;
    prog_level_arg <= lv;
    prog_function_strobe <= 1'b1;
    @(posedge clk) prog_function_strobe <= 1'b0;
    tick(3);
  endtask : fn
  // Clear catchers off the edge so no update is lost
  task automatic clr();
    @(negedge clk);
    jump_seen = 1'b0;
    trap_seen = 1'b0;
  endtask : clr
  task automatic jmp(input int e, input logic [PHASE_W-1:0] ph);
    chk("jump", 8'(e), 8'(jump_seen));
    if (e) chk("jump phase", 8'(ph), 8'(jump_got));
  endtask : jmp
  task automatic dir(input int e);
    chk("direction out", 8'(e), 8'(dir_out));
  endtask : dir
  // Keypad direction press, one cycle long
  task automatic dkey();
    @(posedge clk) dir_key <= 1'b1;
    @(posedge clk) dir_key <= 1'b0;
    tick(3);
  endtask : dkey

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    tick(3);
    chk("motor", 8'h0, 8'(motor));
    dir(1'b1);
    chk("prog out", 8'h0, 8'(prog_out));
    chk("levels", 8'h0F, 8'(host_in));
    // Trigger off, then foot switch with editing lockout
    pin(0, 0); run(0); pin(0, 1); run(0);
    set_mode(TRIG_FOOT);
    pin(0, 0); run(1);
    chk("motor", 8'h1, 8'(motor));
    chk("levels", 8'h0E, 8'(host_in));
    pin(0, 1); run(1);
    @(posedge clk) keypad_editing <= 1'b1;
    pin(0, 0); run(1); pin(0, 1);
    @(posedge clk) keypad_editing <= 1'b0;
    pin(0, 0); run(0); pin(0, 1);
    $display("test foot switch done");
    // Stop diverted to the trap, by trigger and by key
    pin(0, 0); pin(0, 1); clr();
    @(posedge clk) trap_trig <= 1'b1;
    pin(0, 0); run(1); chk("trap", 8'h1, 8'(trap_seen)); pin(0, 1); clr();
    @(posedge clk) trap_key <= 1'b1;
    key(); run(1); chk("trap", 8'h1, 8'(trap_seen));
    @(posedge clk) trap_key <= 1'b0;
    trap_trig <= 1'b0;
    key(); run(0);
    // Zero pause waits for a trigger activation
    key(); fn(FN_WAIT_TRIGGER, '0, 1'b0);
    chk("waiting", 8'h1, 8'(waiting));
    pin(0, 0); chk("waiting", 8'h0, 8'(waiting)); run(1); pin(0, 1);
    done();
    $display("test trap and pause done");
    // Hold, reversed, level control
    set_mode(TRIG_FOOT_HOLD);
    pin(0, 0); run(1); pin(0, 1); run(0);
    set_mode(TRIG_FOOT_REV);
    pin(0, 0); run(0); pin(0, 1); run(1); pin(0, 0); pin(0, 1); run(0);
    set_mode(TRIG_LEVEL_CTRL);
    pin(0, 0); run(0); pin(0, 1); run(1); pin(0, 0); run(0);
    pin(0, 1); done();
    // Start-only refused, started, then repeat ignored; stop-only fall does not start, then stops a key start
    set_mode(TRIG_START_ONLY);
    @(posedge clk) start_allowed <= 1'b0;
    pin(0, 0); run(0); pin(0, 1);
    @(posedge clk) start_allowed <= 1'b1;
    pin(0, 0); run(1); pin(0, 1); pin(0, 0); run(1); pin(0, 1); done();
    set_mode(TRIG_START_REV);
    pin(0, 0); run(0); pin(0, 1); run(1); done();
    set_mode(TRIG_STOP_ONLY);
    pin(0, 0); run(0); pin(0, 1); key(); pin(0, 0); run(0); pin(0, 1);
    set_mode(TRIG_STOP_REV);
    key(); pin(0, 0); run(1); pin(0, 1); run(0);
    $display("test edge modes done");
    // Four level modes
    set_mode(TRIG_RUN_LOW);
    pin(0, 0); run(1); pin(0, 1); run(1); key(); run(0);
    set_mode(TRIG_RUN_HIGH);
    run(1); pin(0, 0); run(1); key(); run(0); pin(0, 1); run(1);
    set_mode(TRIG_STOP_LOW);
    pin(0, 0); run(0);
    set_mode(TRIG_STOP_HIGH);
    key(); run(1); pin(0, 1); run(0);
    set_mode(TRIG_OFF);
    $display("test level modes done");
    // Motor output settings
    @(posedge clk) run_set <= RUN_OUT_PUMP_PAUSE;
    pause_timer_active <= 1'b1;
    tick(3); chk("motor", 8'h1, 8'(motor));
    @(posedge clk) run_set <= 2'h2;
    key(); chk("motor", 8'h0, 8'(motor));
    @(posedge clk) run_set <= RUN_OUT_PUMPING;
    pause_timer_active <= 1'b0;
    tick(3); chk("motor", 8'h1, 8'(motor)); key();
    $display("test motor output done");
    // Direction: reciprocating, then dual, with lockouts and the key
    pin(1, 0); dir(1); pin(1, 1); dir(0); pin(1, 0); dir(1); dkey(); dir(0); pin(1, 1); dir(0);
    @(posedge clk) dir_mode <= DIR_MODE_DUAL;
    pin(1, 0); dir(0); pin(1, 1); dir(1); pin(1, 0); dir(0);
    @(posedge clk) alarm_active <= 1'b1;
    pin(1, 1); dir(0);
    @(posedge clk) alarm_active <= 1'b0;
    dir_key_allowed <= 1'b0;
    pin(1, 0); pin(1, 1); dir(0);
    @(posedge clk) dir_key_allowed <= 1'b1;
    dkey(); dir(1);
    $display("test direction done");
    // Program output by program and by host
    fn(FN_SET_OUTPUT, '0, 1'b1); chk("prog out", 8'h1, 8'(prog_out));
    @(posedge clk) host_out_write <= 1'b1;
    @(posedge clk) host_out_write <= 1'b0;
    tick(3); chk("prog out", 8'h0, 8'(prog_out));
    // Event and conditional jumps while running
    key(); clr(); fn(FN_EDGE_EVENT, 6'h05, 1'b0);
    pin(2, 0); jmp(1, 6'h05); clr();
    fn(FN_EDGE_EVENT, 6'h2A, 1'b0);
    pin(2, 1); jmp(0, '0); pin(2, 0); jmp(1, 6'h2A); clr();
    fn(FN_EITHER_EVENT, 6'h11, 1'b0); pin(2, 1); jmp(1, 6'h11); clr();
    fn(FN_EITHER_EVENT, 6'h3F, 1'b0); pin(2, 0); jmp(1, 6'h3F); pin(2, 1); clr();
    pin(3, 0); chk("levels", 8'h07, 8'(host_in));
    fn(FN_COND_INPUT, 6'h07, 1'b0); tick(2); jmp(1, 6'h07);
    pin(3, 1); clr(); fn(FN_COND_INPUT, 6'h08, 1'b0); tick(2); jmp(0, '0);
    done();
    $display("test program functions done");
    print_verdict();
  end
endmodule : pump_ttl_io_control_test
`default_nettype wire
